// *** hdl/external_interrupt_transfer_request.sv ***
// Eight-input external interrupt and transfer-request unit with APB
// Notes on behaviour
// - Eight request inputs, each with its own detection field.
// - Interrupt use detects high, low, rising or falling edge.
// - Per-input enable gates requests toward the CPU.
// - Detected conditions latch as pending flags per input.
// - Service select 0 means plain interrupt branch.
// - Service select 1 starts automated transfer service first.
// - Requests leave on four request lines, numbers 15, 20, 24, 27.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "ext_req_defs.svh"
module external_interrupt_transfer_request #(
  parameter int NUM_INPUTS = `ERQ_NUM_INPUTS
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [NUM_INPUTS-1:0] ext_request_inputs_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [3:0] cpu_request_out,
  output logic [3:0] transfer_service_out,
  output logic irq_out
);
  localparam int GROUPS = `ERQ_GROUPS;

  logic [NUM_INPUTS-1:0] hit;
  logic [NUM_INPUTS-1:0] request_enable_reg;
  logic [NUM_INPUTS-1:0] request_enable_next;
  logic [NUM_INPUTS-1:0] request_flag_reg;
  logic [NUM_INPUTS-1:0] request_flag_next;
  logic [2*NUM_INPUTS-1:0] detect_level_config_reg;
  logic [2*NUM_INPUTS-1:0] detect_level_config_next;
  logic [GROUPS-1:0] transfer_service_select_reg;
  logic [GROUPS-1:0] transfer_service_select_next;
  logic [NUM_INPUTS-1:0] transfer_request_function;
  logic [NUM_INPUTS-1:0] irq_status_reg;
  logic [NUM_INPUTS-1:0] irq_status_next;
  logic [NUM_INPUTS-1:0] irq_mask_reg;
  logic [NUM_INPUTS-1:0] irq_mask_next;
  logic [NUM_INPUTS-1:0] flag_rise;
  logic [NUM_INPUTS-1:0] flag_prev_reg;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic [3:0] cpu_request_next;
  logic [3:0] transfer_service_next;
  logic irq_next;
  logic wr_en;
  logic rd_en;
  logic bad_addr;

  // Transfer-request function follows the select bit of each input pair
  // pair select
  always_comb begin
    for (int i = 0; i < NUM_INPUTS; i++) begin
      transfer_request_function[i] = transfer_service_select_reg[i / 2];
    end
  end

  // One detector per input; transfer use suppresses edge modes
  // per-input detect
  genvar g;
  generate
    for (g = 0; g < NUM_INPUTS; g++) begin : gen_pin
      pin_detect u_det (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in(ext_request_inputs_in[g]),
        .mode_in(detect_level_config_reg[2*g +: 2]),
        .level_only_in(transfer_request_function[g]),
        .hit_out(hit[g])
      );
    end
  endgenerate

  // APB single-wait slave: answer in the second access cycle
  assign wr_en = psel_in & penable_in & pwrite_in & ~pready_out;
  assign rd_en = psel_in & penable_in & ~pwrite_in & ~pready_out;

  always_comb begin
    bad_addr = 1'b0;
    if (paddr_in == `ERQ_OFS_ENABLE) begin
      prdata_next = {24'h000000, request_enable_reg};
    end else if (paddr_in == `ERQ_OFS_FLAG) begin
      prdata_next = {24'h000000, request_flag_reg};
    end else if (paddr_in == `ERQ_OFS_LEVEL) begin
      prdata_next = {16'h0000, detect_level_config_reg};
    end else if (paddr_in == `ERQ_OFS_SELECT) begin
      prdata_next = {28'h0000000, transfer_service_select_reg};
    end else if (paddr_in == `ERQ_OFS_FUNC) begin
      prdata_next = {24'h000000, transfer_request_function};
    end else if (paddr_in == `ERQ_OFS_IRQ_STATUS) begin
      prdata_next = {24'h000000, irq_status_reg};
    end else if (paddr_in == `ERQ_OFS_IRQ_MASK) begin
      prdata_next = {24'h000000, irq_mask_reg};
    end else begin
      prdata_next = 32'h00000000;
      bad_addr = 1'b1;
    end
    if (!rd_en) begin
      prdata_next = 32'h00000000;
    end
    pready_next = psel_in & penable_in & ~pready_out;
    pslverr_next = pready_next & bad_addr;
  end

  // Register writes; flags are set by hardware, written 0 to clear
  always_comb begin
    request_enable_next = request_enable_reg;
    detect_level_config_next = detect_level_config_reg;
    transfer_service_select_next = transfer_service_select_reg;
    irq_mask_next = irq_mask_reg;
    request_flag_next = request_flag_reg;
    irq_status_next = irq_status_reg;
    if (wr_en) begin
      if (paddr_in == `ERQ_OFS_ENABLE) begin
        request_enable_next = pwdata_in[NUM_INPUTS-1:0];
      end else if (paddr_in == `ERQ_OFS_FLAG) begin
        request_flag_next = request_flag_reg & pwdata_in[NUM_INPUTS-1:0];
      end else if (paddr_in == `ERQ_OFS_LEVEL) begin
        detect_level_config_next = pwdata_in[2*NUM_INPUTS-1:0];
      end else if (paddr_in == `ERQ_OFS_SELECT) begin
        transfer_service_select_next = pwdata_in[GROUPS-1:0];
      end else if (paddr_in == `ERQ_OFS_IRQ_STATUS) begin
        irq_status_next = irq_status_reg & ~pwdata_in[NUM_INPUTS-1:0];
      end else if (paddr_in == `ERQ_OFS_IRQ_MASK) begin
        irq_mask_next = pwdata_in[NUM_INPUTS-1:0];
      end
    end
    request_flag_next = request_flag_next | hit;
    irq_status_next = irq_status_next | flag_rise;
  end

  // New flag arrivals feed the sticky interrupt status
  assign flag_rise = request_flag_reg & ~flag_prev_reg;

  // Outputs toward the CPU interrupt logic, one line per input pair
  // four request lines
  always_comb begin
    for (int k = 0; k < GROUPS; k++) begin
      cpu_request_next[k] = |(request_flag_next[2*k +: 2] &
                              request_enable_next[2*k +: 2]);
      transfer_service_next[k] = cpu_request_next[k] &
                                 transfer_service_select_next[k];
    end
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // Registered state; everything cleared or disabled at reset
  // reset clears
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      request_enable_reg <= `ERQ_RST_BYTE;
      request_flag_reg <= `ERQ_RST_BYTE;
      flag_prev_reg <= `ERQ_RST_BYTE;
      detect_level_config_reg <= `ERQ_RST_LEVEL;
      transfer_service_select_reg <= `ERQ_RST_SELECT;
      irq_status_reg <= `ERQ_RST_BYTE;
      irq_mask_reg <= `ERQ_RST_BYTE;
      prdata_out <= 32'h00000000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      cpu_request_out <= 4'h0;
      transfer_service_out <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      request_enable_reg <= request_enable_next;
      request_flag_reg <= request_flag_next;
      flag_prev_reg <= request_flag_reg;
      detect_level_config_reg <= detect_level_config_next;
      transfer_service_select_reg <= transfer_service_select_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      prdata_out <= prdata_next;
      pready_out <= pready_next;
      pslverr_out <= pslverr_next;
      cpu_request_out <= cpu_request_next;
      transfer_service_out <= transfer_service_next;
      irq_out <= irq_next;
    end
  end
endmodule

// *** hdl/ext_req_defs.svh ***
// Register offsets, field layouts and reset values of the request unit
`ifndef EXT_REQ_DEFS_SVH
`define EXT_REQ_DEFS_SVH
`define ERQ_NUM_INPUTS 8
`define ERQ_OFS_ENABLE 12'h000
`define ERQ_OFS_FLAG 12'h004
`define ERQ_OFS_LEVEL 12'h008
`define ERQ_OFS_SELECT 12'h00C
`define ERQ_OFS_FUNC 12'h010
`define ERQ_OFS_IRQ_STATUS 12'h014
`define ERQ_OFS_IRQ_MASK 12'h018
`define ERQ_RST_BYTE 8'h00
`define ERQ_RST_LEVEL 16'h0000
`define ERQ_RST_SELECT 4'h0
`define ERQ_GROUPS 4
`define ERQ_SYNC_FILL 2'h3
`endif

// *** hdl/ext_req_pkg.sv ***
// Types shared by the request unit
package ext_req_pkg;
  // Detection field encoding, two bits per input
  typedef enum logic [1:0] {
    DET_LOW = 2'b00,
    DET_HIGH = 2'b01,
    DET_RISE = 2'b10,
    DET_FALL = 2'b11
  } detect_mode_t;
endpackage

// *** hdl/pin_detect.sv ***
// One request input: three-stage synchroniser and level/edge detector
`timescale 1ns/1ns
`include "ext_req_defs.svh"
module pin_detect (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic pin_in,
  input wire logic [1:0] mode_in,
  input wire logic level_only_in,
  output logic hit_out
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic stable_reg;
  logic stable_next;
  logic [1:0] fill_reg;
  logic [1:0] fill_next;
  logic hit_next;
  ext_req_pkg::detect_mode_t mode;

  // Once the chain is filled, stable level moves only when stages two and three agree
  always_comb begin
    mode = ext_req_pkg::detect_mode_t'(mode_in);
    sync_next = {sync_reg[1:0], pin_in};
    fill_next = fill_reg;
    stable_next = stable_reg;
    if (sync_reg[1] == sync_reg[2]) begin
      stable_next = sync_reg[2];
    end
    hit_next = 1'b0;
    case (mode)
      ext_req_pkg::DET_LOW: hit_next = ~stable_next;
      ext_req_pkg::DET_HIGH: hit_next = stable_next;
      ext_req_pkg::DET_RISE: hit_next = ~level_only_in &
                             stable_next & ~stable_reg;
      ext_req_pkg::DET_FALL: hit_next = ~level_only_in &
                             ~stable_next & stable_reg;
      default: hit_next = 1'b0;
    endcase
    // Track the pin only until the chain holds real samples; the reset
    // view may differ from the idle pin and would fake a level or edge
    if (fill_reg != `ERQ_SYNC_FILL) begin
      fill_next = fill_reg + 2'h1;
      stable_next = sync_reg[1];
      hit_next = 1'b0;
    end
  end

  // Reset to idle-low view of the pin
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_reg <= 3'h0;
      stable_reg <= 1'b0;
      fill_reg <= 2'h0;
      hit_out <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      stable_reg <= stable_next;
      fill_reg <= fill_next;
      hit_out <= hit_next;
    end
  end
endmodule

// *** verif/eitr_props.sv ***
// Port checker for the external request unit
`timescale 1ns/1ns
module eitr_props (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [3:0] cpu_request_out,
  input wire logic [3:0] transfer_service_out,
  input wire logic irq_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // Bus answers after exactly one wait state, as a single pulse
  a_ready_one_wait:
    assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  a_ready_pulse:
    assert property (pready_out |=> !pready_out)
    else $error("pready stuck");
  a_err_with_ready:
    assert property (pslverr_out |-> pready_out)
    else $error("stray pslverr");
  a_err_unmapped:
    assert property (pready_out && paddr_in > 12'h018
    |-> pslverr_out && prdata_out == 32'h0) else $error("bad refuse");
  a_rdata_idle:
    assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("stray read data");
  a_service_needs_req:
    assert property ((transfer_service_out & ~cpu_request_out) == 4'h0)
    else $error("service without request");
  // Latched requests fall only through a software write
  a_req_held:
    assert property (|($past(cpu_request_out) & ~cpu_request_out)
    |-> pready_out && pwrite_in) else $error("request dropped");
  a_irq_held:
    assert property ($fell(irq_out) |-> pready_out && pwrite_in)
    else $error("irq dropped");
  c_refused: cover property (pslverr_out);
  c_service: cover property (|transfer_service_out);
  c_irq: cover property ($rose(irq_out));
endmodule
bind external_interrupt_transfer_request eitr_props chk (.mclk_in,
  .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .prdata_out,
  .pready_out, .pslverr_out, .cpu_request_out, .transfer_service_out,
  .irq_out);

// *** verif/ext_peripheral.sv ***
// Behavioural peripherals driving the request pins
`timescale 1ns/1ns
module ext_peripheral (
  input wire logic mclk_in,
  input wire logic [7:0] want_in,
  input wire logic [7:0] active_high_in,
  output logic [7:0] pins_out
);
  // drive configured condition
  // Requesting shows the active level, idle its inverse, so edges follow
  always @(posedge mclk_in) begin
    pins_out <= ~(want_in ^ active_high_in);
  end
endmodule

// *** verif/external_interrupt_transfer_request_bench.sv ***
// Self-checking bench for the external request unit
`timescale 1ns/1ns
module external_interrupt_transfer_request_bench;
  logic mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, err, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] cpu_req, svc;
  logic [7:0] pins, want = 8'h00, acth = 8'h00;
  int fails = 0, check_count = 0;
  // 4 ns machine clock
  always #2 mclk = ~mclk;
  // Unit and the peripherals on its pins
  external_interrupt_transfer_request uut (.mclk_in(mclk), .rst_b_in(rst_b),
    .ext_request_inputs_in(pins), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cpu_request_out(cpu_req), .transfer_service_out(svc), .irq_out(irq));
  ext_peripheral dev (.mclk_in(mclk), .want_in(want), .active_high_in(acth),
    .pins_out(pins));
  task chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until pready is sampled high, then released
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] exp, input string s);
    apb(1'h0, a, 32'h0);
    chk(s, exp, rd);
  endtask
  // Pins pass a synchroniser, so allow them time to land
  task settle;
    repeat (10) @(posedge mclk);
  endtask
  // Drop requests, then clear flags and sticky status
  task idle;
    want <= 8'h00;
    settle;
    apb(1'h1, 12'h004, 32'h0);
    apb(1'h1, 12'h014, 32'hFF);
  endtask
  task t_reset;
    for (int i = 0; i < 8; i++) begin
      rchk(12'(i * 4), 32'h0, "reset word");
      chk("error", 32'(i == 7), 32'(err));
    end
    chk("lines", 32'h0, 32'({cpu_req, svc, irq}));
    $display("reset test done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      acth <= {7'h7F, 1'(m == 1 || m == 2)};
      apb(1'h1, 12'h008, 32'h5554 | m);
      apb(1'h1, 12'h000, 32'h01);
      idle;
      want <= 8'h01;
      settle;
      rchk(12'h004, 32'h01, "flag");
      chk("line", 32'h1, 32'(cpu_req));
      apb(1'h1, 12'h004, 32'h0);
      settle;
      rchk(12'h004, 32'(m < 2), "flag after clear");
    end
    $display("mode test done");
  endtask
  task t_lines;
    acth <= 8'hFF;
    apb(1'h1, 12'h008, 32'h5555);
    apb(1'h1, 12'h000, 32'h55);
    for (int i = 0; i < 8; i++) begin
      idle;
      want <= 8'(1 << i);
      settle;
      rchk(12'h004, 32'(1 << i), "pin flag");
      chk("line", i % 2 ? 32'h0 : 32'(1 << (i / 2)), 32'(cpu_req));
    end
    $display("line test done");
  endtask
  task t_service;
    apb(1'h1, 12'h00C, 32'h2);
    rchk(12'h010, 32'h0C, "transfer function");
    apb(1'h1, 12'h000, 32'h04);
    idle;
    want <= 8'h04;
    settle;
    chk("transfer", 32'h22, 32'({svc, cpu_req}));
    apb(1'h1, 12'h00C, 32'h0);
    repeat (2) @(posedge mclk);
    chk("plain", 32'h02, 32'({svc, cpu_req}));
    apb(1'h1, 12'h008, 32'h5565);
    apb(1'h1, 12'h00C, 32'h2);
    idle;
    want <= 8'h04;
    settle;
    rchk(12'h004, 32'h0, "edge in transfer");
    $display("service test done");
  endtask
  task t_irq;
    apb(1'h1, 12'h008, 32'h5555);
    apb(1'h1, 12'h018, 32'h01);
    idle;
    want <= 8'h01;
    settle;
    chk("irq", 32'h1, 32'(irq));
    apb(1'h1, 12'h018, 32'h0);
    repeat (2) @(posedge mclk);
    chk("masked", 32'h0, 32'(irq));
    apb(1'h1, 12'h018, 32'h01);
    want <= 8'h00;
    repeat (2) @(posedge mclk);
    chk("unmasked", 32'h1, 32'(irq));
    rchk(12'h004, 32'h01, "flag held");
    apb(1'h1, 12'h014, 32'h01);
    repeat (2) @(posedge mclk);
    chk("cleared", 32'h0, 32'(irq));
    $display("irq test done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence after six cycles of reset
  initial begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    t_reset;
    t_modes;
    t_lines;
    t_service;
    t_irq;
    close_out;
  end
  // Tests need about 700 cycles; a hang stops well beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    close_out;
  end
endmodule
